// *** adc_clk_divider.sv ***
`timescale 1ns/100ps
`default_nettype none
module adc_clk_divider (
  input wire logic ref_clk, // Master clock
  input wire logic rst, // Synchronous reset, high
  input wire logic run, // Divider runs while high
  input wire logic [1:0] div_code, // Divide select code
  output logic tick // One-cycle ADC clock enable
);
  import adc_ctrl_pkg::*;

  typedef struct packed {
    logic [5:0] cnt;
    logic tick;
  } div_state_t;

  div_state_t s;
  div_state_t next_s;
  logic [5:0] ratio;

  // ==========================================================
  // Ratio lookup
  // ==========================================================
  always_comb begin
    case (div_code)
      2'b00: ratio = DIV_RATIO_00;
      2'b01: ratio = DIV_RATIO_01;
      2'b10: ratio = DIV_RATIO_10;
      default: ratio = DIV_RATIO_11;
    endcase
  end

  // Count to ratio-1, then pulse; a code change takes effect at once against the running count
  always_comb begin
    next_s = s;
    next_s.tick = 1'b0;
    if (!run) begin
      next_s.cnt = 6'h00;
    end else if (s.cnt >= ratio - 6'h01) begin
      next_s.cnt = 6'h00;
      next_s.tick = 1'b1;
    end else begin
      next_s.cnt = s.cnt + 6'h01;
    end
  end

  // State register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tick = s.tick;
endmodule
`default_nettype wire

// *** adc_converter_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// Converter model behind the control block
// ==========================================
module adc_converter_model (
  input wire logic ref_clk, // Master clock
  input wire logic conv_start, // Convert command
  input wire logic [7:0] delay, // Cycles per conversion
  input wire logic [11:0] code_in, // Code to hand back
  output logic conv_done, // Finished pulse
  output logic [11:0] conv_code // Result code
);
  int cnt = 0;
  initial conv_done = 1'b0;
  initial conv_code = 12'h5a5;
  // Count a conversion down; idle code bus toggles so stale reads show
  always @(posedge ref_clk) begin
    conv_done <= 1'b0;
    conv_code <= ~conv_code;
    if (conv_start) begin
      cnt = delay + 1;
    end else if (cnt > 1) begin
      cnt--;
    end else if (cnt == 1) begin
      cnt = 0;
      conv_done <= 1'b1;
      conv_code <= code_in;
    end
  end
endmodule
`default_nettype wire

// *** adc_ctrl_pkg.sv ***
`default_nettype none
package adc_ctrl_pkg;

  // ==========================================================
  // Register map of the special function register window
  // ==========================================================
  localparam logic [7:0] CFG_ADDR = 8'hef;
  localparam logic [7:0] RES_LO_ADDR = 8'hd9;
  localparam logic [7:0] RES_HI_ADDR = 8'hda;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] RDATA_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // ==========================================================
  // Field positions in adc_power_clock_config
  // ==========================================================
  localparam int POWER_POS = 7;
  localparam int REF_POS = 6;
  localparam int DIV_HI_POS = 5;
  localparam int DIV_LO_POS = 4;
  localparam int ACQ_HI_POS = 3;
  localparam int ACQ_LO_POS = 2;
  localparam int TIMER_TRIG_POS = 1;
  localparam int PIN_TRIG_POS = 0;

  // ==========================================================
  // Clock divide ratios of the master clock, per code
  // ==========================================================
  localparam logic [5:0] DIV_RATIO_00 = 6'h08;
  localparam logic [5:0] DIV_RATIO_01 = 6'h04;
  localparam logic [5:0] DIV_RATIO_10 = 6'h10;
  localparam logic [5:0] DIV_RATIO_11 = 6'h20;
  // Ceiling on the ADC clock that software keeps to
  localparam int ADC_CLK_MAX_KHZ = 4500;

  // ==========================================================
  // Result, channel and capture widths
  // ==========================================================
  localparam int RESULT_BITS = 12;
  localparam int CODE_STEPS = 4096;
  localparam int CHAN_BITS = 4;
  localparam logic [3:0] TEMP_CHANNEL = 4'h8;
  localparam int DMA_ADDR_BITS = 24;
  localparam logic [23:0] DMA_ADDR_RESET = 24'h000000;
  localparam logic [23:0] DMA_ADDR_STEP = 24'h000002;
  localparam int CAL_BITS = 12;

  // ==========================================================
  // Carriers
  // ==========================================================
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } sfr_req_t;

  typedef struct packed {
    logic [CAL_BITS-1:0] offset;
    logic [CAL_BITS-1:0] gain;
  } cal_coeff_t;

  typedef struct packed {
    logic valid;
    logic [DMA_ADDR_BITS-1:0] addr;
    logic [15:0] data;
  } dma_word_t;

  typedef enum logic [2:0] {
    ST_OFF,
    ST_IDLE,
    ST_ACQ,
    ST_CONV,
    ST_STORE
  } seq_state_t;

endpackage
`default_nettype wire

// *** adc_ctrl_props.sv ***
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// Checks at the ports of the control block
// ==========================================
module adc_ctrl_props (
  input wire logic ref_clk, // Clock
  input wire logic rst, // Reset
  input wire adc_ctrl_pkg::sfr_req_t sfr, // Register access
  input wire logic dma_ready, // RAM accept
  input wire adc_ctrl_pkg::cal_coeff_t cal_factory, // Factory values
  input wire logic converter_power, // Power
  input wire logic outside_reference_select_select, // Reference
  input wire logic [3:0] mux_select, // Channel
  input wire logic temp_select, // Temperature route
  input wire logic track_enable, // Acquiring
  input wire logic conv_start, // Convert pulse
  input wire logic adc_clk_tick, // ADC clock enable
  input wire adc_ctrl_pkg::cal_coeff_t cal_out, // Calibration
  input wire adc_ctrl_pkg::dma_word_t dma_out // DMA word
);
  import adc_ctrl_pkg::*;
  // One domain, so clock and reset are stated once
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  property p_power;
    sfr.wr && sfr.addr == CFG_ADDR |=>
      converter_power == $past(sfr.wdata[POWER_POS]);
  endproperty
  a_power: assert property (p_power) else $error("power bit lost");
  property p_ref;
    sfr.wr && sfr.addr == CFG_ADDR |=>
      outside_reference_select_select == $past(sfr.wdata[REF_POS]);
  endproperty
  a_ref: assert property (p_ref) else $error("ref bit lost");
  // Smallest ratio is four, so three quiet cycles follow any tick
  property p_tick_gap;
    adc_clk_tick |=> !adc_clk_tick [*3];
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("tick too soon");
  property p_tick_off;
    !converter_power |=> !adc_clk_tick;
  endproperty
  a_tick_off: assert property (p_tick_off) else $error("tick off");
  property p_temp;
    temp_select == (mux_select == TEMP_CHANNEL);
  endproperty
  a_temp: assert property (p_temp) else $error("temp route");
  property p_start;
    conv_start |-> $past(track_enable) ##1 !conv_start;
  endproperty
  a_start: assert property (p_start) else $error("start pulse");
  property p_accept;
    dma_out.valid && dma_ready && !sfr.wr |=> !dma_out.valid &&
      dma_out.addr == $past(dma_out.addr) + DMA_ADDR_STEP;
  endproperty
  a_accept: assert property (p_accept) else $error("dma step");
  property p_cal;
    $fell(rst) |=> cal_out == $past(cal_factory);
  endproperty
  a_cal: assert property (p_cal) else $error("cal load");
endmodule
bind sar_adc_control adc_ctrl_props u_props (.ref_clk, .rst, .sfr,
  .dma_ready, .cal_factory, .converter_power, .outside_reference_select_select,
  .mux_select, .temp_select, .track_enable, .conv_start, .adc_clk_tick,
  .cal_out, .dma_out);
`default_nettype wire

// *** sar_adc_control.sv ***
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - Result is unsigned straight binary, twelve bits, step of full scale/4096.
// - Each result fills both result bytes; high nibble carries channel.
// - Config bit 7 powers the converter up when set, down when clear.
// - Config bit 6 picks outside reference when set, internal when clear.
// - Divide field codes 00, 01, 10 divide master clock by 8, 4, 16.
// - Single mode starts by software or by the pin; continuous mode starts by software alone.
// - Timer 2 can serve as a repetitive conversion start source.
// - DMA mode converts continuously, storing samples over a 16 MB space.
// - Factory calibration coefficients load automatically after power-up.
// - Offset and gain registers can be rewritten by hardware calibration.
// - Temperature voltage is a ninth selectable input of the mux.
// - Config register supports byte access only, no single-bit access.
// - Bits 3:2 set acquisition of 1 to 4 ADC clocks.
// - Config bit 1 lets Timer 2 overflow start a conversion.
// - Config bit 0 enables the active-low pin start; party pulses it low.
module sar_adc_control (
  input wire logic ref_clk, // Master clock, 125 MHz
  input wire logic rst, // Synchronous reset, high
  input wire adc_ctrl_pkg::sfr_req_t sfr, // Byte register access
  output logic [7:0] sfr_rdata, // Read data, one cycle after rd
  input wire logic [3:0] channel_select, // Mux channel, 8 = temperature
  input wire logic soft_single_start, // Pulse: one conversion
  input wire logic soft_continuous, // Level: convert back to back
  input wire logic dma_enable, // Level: continuous capture to RAM
  input wire logic timer_two_overflow, // Pulse from Timer 2
  input wire logic pin_convert_start_n, // Asynchronous pin, active low
  input wire logic conv_done, // Pulse: converter finished
  input wire logic [11:0] conv_code, // Converter result code
  input wire adc_ctrl_pkg::cal_coeff_t cal_factory, // Factory values
  input wire logic cal_update, // Pulse: hardware calibration result
  input wire adc_ctrl_pkg::cal_coeff_t cal_new, // New calibration values
  input wire logic dma_ready, // RAM accepted the DMA word
  output logic converter_power, // Converter powered up
  output logic outside_reference_select_select, // Outside reference selected
  output logic [3:0] mux_select, // Channel driven to the mux
  output logic temp_select, // Temperature input routed
  output logic track_enable, // Track-and-hold acquiring
  output logic conv_start, // One-cycle convert command
  output logic adc_clk_tick, // ADC clock enable pulse
  output adc_ctrl_pkg::cal_coeff_t cal_out, // Calibration registers
  output adc_ctrl_pkg::dma_word_t dma_out, // DMA write request
  output logic busy // Conversion sequence in progress
);
  import adc_ctrl_pkg::*;

  // ==========================================================
  // Block state
  // ==========================================================
  typedef struct packed {
    logic [7:0] cfg;
    logic [7:0] rdata;
    logic [11:0] result;
    logic [3:0] result_chan;
    logic [1:0] pin_sync;
    logic pin_prev;
    seq_state_t state;
    logic [2:0] acq_cnt;
    logic [3:0] chan;
    logic single;
    logic conv_start;
    logic cal_loaded;
    cal_coeff_t cal;
    logic dma_valid;
    logic [23:0] dma_addr;
    logic [15:0] dma_data;
  } ctrl_state_t;

  ctrl_state_t s;
  ctrl_state_t next_s;
  logic tick;
  logic pin_fall;
  logic hw_trigger;
  logic soft_trigger;
  logic repeat_run;
  logic [2:0] acq_last;
  logic [7:0] hi_byte;
  logic [7:0] lo_byte;

  // ==========================================================
  // ADC clock generation
  // ==========================================================
  adc_clk_divider u_div (
    .ref_clk(ref_clk),
    .rst(rst),
    .run(s.cfg[POWER_POS]),
    .div_code({s.cfg[DIV_HI_POS], s.cfg[DIV_LO_POS]}),
    .tick(tick)
  );

  // ==========================================================
  // Start sources
  // ==========================================================
  // Falling edge seen only past the second synchroniser stage
  assign pin_fall = s.pin_prev & ~s.pin_sync[1];
  // Hardware starts, each gated by its own enable bit
  assign hw_trigger = (pin_fall & s.cfg[PIN_TRIG_POS])
    | (timer_two_overflow & s.cfg[TIMER_TRIG_POS]);
  assign soft_trigger = soft_single_start | soft_continuous;
  // Back-to-back conversions while continuous or DMA mode holds
  assign repeat_run = soft_continuous | dma_enable;
  // Code n means n+1 ADC clocks of acquisition
  assign acq_last = {1'b0, s.cfg[ACQ_HI_POS], s.cfg[ACQ_LO_POS]};

  // Result word: channel tag in the top nibble of the high byte
  assign hi_byte = {s.result_chan, s.result[11:8]};
  assign lo_byte = s.result[7:0];

  // ==========================================================
  // Next-state logic
  // ==========================================================
  always_comb begin
    next_s = s;
    next_s.conv_start = 1'b0;

    // Pin synchroniser; first stage feeds the second only
    next_s.pin_sync = {s.pin_sync[0], pin_convert_start_n};
    next_s.pin_prev = s.pin_sync[1];

    // Byte-wide access only; no bit-address path exists
    if (sfr.wr && sfr.addr == CFG_ADDR) begin
      next_s.cfg = sfr.wdata;
    end
    if (sfr.rd) begin
      case (sfr.addr)
        CFG_ADDR: next_s.rdata = s.cfg;
        RES_HI_ADDR: next_s.rdata = hi_byte;
        RES_LO_ADDR: next_s.rdata = lo_byte;
        default: next_s.rdata = UNMAPPED_READ;
      endcase
    end

    // Factory load once after reset, later hardware updates overwrite
    if (!s.cal_loaded) begin
      next_s.cal = cal_factory;
      next_s.cal_loaded = 1'b1;
    end else if (cal_update) begin
      next_s.cal = cal_new;
    end

    // Conversion sequencer
    case (s.state)
      ST_OFF: begin
        if (s.cfg[POWER_POS]) begin
          next_s.state = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (soft_trigger || hw_trigger || dma_enable) begin
          next_s.state = ST_ACQ;
          next_s.acq_cnt = 3'h0;
          next_s.chan = channel_select;
          next_s.single = ~repeat_run;
        end
      end
      ST_ACQ: begin
        // Acquisition counted in ADC clocks, not master clocks
        if (tick) begin
          if (s.acq_cnt == acq_last) begin
            next_s.state = ST_CONV;
            next_s.conv_start = 1'b1;
          end else begin
            next_s.acq_cnt = s.acq_cnt + 3'h1;
          end
        end
      end
      ST_CONV: begin
        if (conv_done) begin
          // Raw code kept unsigned, no sign or offset applied
          next_s.result = conv_code;
          next_s.result_chan = s.chan;
          if (dma_enable) begin
            next_s.dma_valid = 1'b1;
            next_s.dma_data = {s.chan, conv_code};
            next_s.state = ST_STORE;
          end else if (repeat_run && !s.single) begin
            next_s.state = ST_ACQ;
            next_s.acq_cnt = 3'h0;
            next_s.chan = channel_select;
          end else begin
            next_s.state = ST_IDLE;
          end
        end
      end
      ST_STORE: begin
        // RAM stall holds the sequencer; no sample is dropped
        if (dma_ready) begin
          next_s.dma_valid = 1'b0;
          // Address wraps at the top of the 16 MB space
          next_s.dma_addr = s.dma_addr + DMA_ADDR_STEP;
          if (repeat_run) begin
            next_s.state = ST_ACQ;
            next_s.acq_cnt = 3'h0;
            next_s.chan = channel_select;
          end else begin
            next_s.state = ST_IDLE;
          end
        end
      end
      default: begin
        next_s.state = ST_OFF;
      end
    endcase

    // Power-down aborts any sequence in flight
    if (!s.cfg[POWER_POS]) begin
      next_s.state = ST_OFF;
      next_s.dma_valid = 1'b0;
    end

    // Leaving DMA mode restarts capture at the base address
    if (!dma_enable && s.state != ST_STORE) begin
      next_s.dma_addr = DMA_ADDR_RESET;
    end
  end

  // ==========================================================
  // State register
  // ==========================================================
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s <= '0;
      s.cfg <= CFG_RESET;
      s.rdata <= RDATA_RESET;
      s.pin_sync <= 2'h3;
      s.pin_prev <= 1'b1;
      s.state <= ST_OFF;
      s.dma_addr <= DMA_ADDR_RESET;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================
  // Outputs, taken from the state register except adc_clk_tick, which comes from the divider
  // ==========================================================
  assign sfr_rdata = s.rdata;
  assign converter_power = s.cfg[POWER_POS];
  assign outside_reference_select_select = s.cfg[REF_POS];
  assign mux_select = s.chan;
  assign temp_select = (s.chan == TEMP_CHANNEL);
  assign track_enable = (s.state == ST_ACQ);
  assign conv_start = s.conv_start;
  assign adc_clk_tick = tick;
  assign cal_out = s.cal;
  assign dma_out = '{valid: s.dma_valid, addr: s.dma_addr,
                     data: s.dma_data};
  assign busy = (s.state == ST_ACQ) || (s.state == ST_CONV)
    || (s.state == ST_STORE);
endmodule
`default_nettype wire

// *** testbench.sv ***
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import adc_ctrl_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  sfr_req_t sfr = '0;
  logic [7:0] sfr_rdata, d, cfg, delay = 8'h04;
  logic [3:0] channel_select = 4'h0, mux_select;
  logic soft_single_start = 1'b0, soft_continuous = 1'b0;
  logic dma_enable = 1'b0, timer_two_overflow = 1'b0, cal_update = 1'b0;
  logic pin_convert_start_n = 1'b1, dma_ready = 1'b0, conv_done, busy;
  logic converter_power, outside_reference_select_select, temp_select, track_enable;
  logic conv_start, adc_clk_tick;
  logic [11:0] conv_code, code_in = 12'h000;
  cal_coeff_t cal_factory = 24'h3a5c71, cal_new = '0, cal_out;
  dma_word_t dma_out;
  int seed = 22, miscompares = 0, tests_run = 0, n;
  int cyc = 0, last_tick = 0, tick_gap = 0, acq_ticks = 0;
  int ratio[4] = '{8, 4, 16, 32};
  sar_adc_control DUT (.ref_clk, .rst, .sfr, .sfr_rdata, .channel_select,
    .soft_single_start, .soft_continuous, .dma_enable, .timer_two_overflow,
    .pin_convert_start_n, .conv_done, .conv_code, .cal_factory, .cal_update,
    .cal_new, .dma_ready, .converter_power, .outside_reference_select_select, .mux_select,
    .temp_select, .track_enable, .conv_start, .adc_clk_tick, .cal_out,
    .dma_out, .busy);
  adc_converter_model conv_side (.ref_clk, .conv_start, .delay, .code_in,
    .conv_done, .conv_code);
  initial forever #4 ref_clk = ~ref_clk;
  // Tick spacing, ticks spent acquiring, and the hang limit
  always @(posedge ref_clk) begin
    cyc++;
    if (adc_clk_tick === 1'b1) begin
      tick_gap = cyc - last_tick;
      last_tick = cyc;
      if (track_enable === 1'b1) acq_ticks++;
    end
    if (cyc == 30000) begin
      miscompares++;
      wrap_up;
    end
  end
  // ==========================================
  // Tasks
  // ==========================================
  task automatic chk(input string s, input logic [31:0] e, g);
    tests_run++;
    if (e !== g) begin
      miscompares++;
      $display("BAD %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, v);
    @(posedge ref_clk);
    sfr <= '{a, v, 1'b1, 1'b0};
    @(posedge ref_clk);
    sfr.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    sfr <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge ref_clk);
    sfr.rd <= 1'b0;
    #1 d = sfr_rdata;
  endtask
  // Power off first so the divider always restarts cleanly
  task automatic setcfg(input logic [7:0] v);
    wr(CFG_ADDR, 8'h00);
    wr(CFG_ADDR, v);
    cfg = v;
  endtask
  task automatic trig(input int k);
    @(posedge ref_clk);
    case (k)
      0: soft_single_start <= 1'b1;
      1: timer_two_overflow <= 1'b1;
      default: pin_convert_start_n <= 1'b0;
    endcase
    @(posedge ref_clk);
    soft_single_start <= 1'b0;
    timer_two_overflow <= 1'b0;
    repeat (16) @(posedge ref_clk);
    pin_convert_start_n <= 1'b1;
  endtask
  task automatic conv(input int k, input logic [3:0] ch);
    logic [11:0] c;
    c = 12'($random(seed));
    @(posedge ref_clk);
    channel_select <= ch;
    code_in <= c;
    delay <= 8'($random(seed) & 31) + 8'h01;
    acq_ticks = 0;
    trig(k);
    n = 0;
    while (busy !== 1'b0 && n < 3000) begin
      @(posedge ref_clk);
      n++;
    end
    rd(RES_HI_ADDR);
    chk("res_hi", {ch, c[11:8]}, d);
    rd(RES_LO_ADDR);
    chk("res_lo", c[7:0], d);
    chk("temp", ch == TEMP_CHANNEL, temp_select);
    chk("mux", ch, mux_select);
  endtask
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ==========================================
  // Main sequence
  // ==========================================
  initial begin
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1 chk("cal", cal_factory, cal_out);
    rd(CFG_ADDR);
    chk("cfg0", 8'h00, d);
    for (int i = 0; i < 4; i++) begin
      setcfg({1'b1, 1'($random(seed)), 2'(i), 4'h0});
      repeat (80) @(posedge ref_clk);
      chk("gap", ratio[i], tick_gap);
      chk("pwr", cfg[7:6], {converter_power, outside_reference_select_select});
      rd(CFG_ADDR);
      chk("cfg", cfg, d);
    end
    for (int a = 0; a < 4; a++) begin
      setcfg({2'b10, 2'(a), 2'(a), 2'b11});
      conv(a % 3, a == 3 ? 4'h8 : 4'(a + 2));
      chk("acq", a + 1, acq_ticks);
    end
    setcfg(8'h80);
    trig(1);
    trig(2);
    #1 chk("noarm", 1'b0, busy);
    setcfg(8'h00);
    trig(0);
    repeat (60) @(posedge ref_clk);
    #1 chk("off", 1'b0, busy | (cyc - last_tick < 60));
    setcfg(8'h94);
    @(posedge ref_clk);
    channel_select <= 4'h5;
    code_in <= 12'($random(seed));
    dma_enable <= 1'b1;
    for (int w = 0; w < 4; w++) begin
      n = 0;
      do begin
        @(posedge ref_clk);
        dma_ready <= 1'($random(seed));
        @(negedge ref_clk);
        n++;
      end while (!(dma_out.valid === 1'b1 && dma_ready === 1'b1) && n < 3000);
      chk("daddr", w * 2, dma_out.addr);
      chk("ddata", {4'h5, code_in}, dma_out.data);
    end
    @(posedge ref_clk);
    dma_enable <= 1'b0;
    dma_ready <= 1'b1;
    repeat (400) @(posedge ref_clk);
    wr(RES_HI_ADDR, 8'hff);
    rd(RES_HI_ADDR);
    chk("ro", {4'h5, code_in[11:8]}, d);
    rd(8'hee);
    chk("unmap", UNMAPPED_READ, d);
    @(posedge ref_clk);
    cal_new <= 24'($random(seed));
    cal_update <= 1'b1;
    @(posedge ref_clk);
    cal_update <= 1'b0;
    @(posedge ref_clk);
    #1 chk("calu", cal_new, cal_out);
    // Continuous mode at divide 32 keeps the ADC clock legal
    setcfg(8'hb0);
    @(posedge ref_clk);
    soft_continuous <= 1'b1;
    repeat (300) @(posedge ref_clk);
    #1 chk("cont", 1'b1, busy);
    @(posedge ref_clk);
    soft_continuous <= 1'b0;
    repeat (400) @(posedge ref_clk);
    #1 chk("cstop", 1'b0, busy);
    wrap_up;
  end
endmodule
`default_nettype wire
